// file: hw/bft_regs.svh
`ifndef BFT_REGS_SVH
`define BFT_REGS_SVH
`define BFT_ADDR_CTRL      4'h0
`define BFT_ADDR_RETR_DLY  4'h1
`define BFT_ADDR_BF_DLY    4'h2
`define BFT_ADDR_PH_THR    4'h3
`define BFT_ADDR_RES_THR   4'h4
`define BFT_ADDR_STATUS    4'h5
`define BFT_ADDR_IRQ_STAT  4'h6
`define BFT_ADDR_IRQ_CLR   4'h7
`define BFT_ADDR_IRQ_EN    4'h8
`define BFT_CTRL_RETR_EN   0
`define BFT_CTRL_MODE_LSB  1
`define BFT_CTRL_MODE_MSB  4
`define BFT_CTRL_RESET     32'h0000_0001
`define BFT_RETR_DLY_RESET 16'h0014
`define BFT_BF_DLY_RESET   16'h0028
`define BFT_PH_THR_RESET   16'h0014
`define BFT_RES_THR_RESET  16'h04B0
`define BFT_STEP_NS        5000000
`define BFT_CLK_NS         25
`define BFT_RATIO_NUM      97
`define BFT_RATIO_DEN      100
`define BFT_NUM_EVT        4
`endif

// file: hw/bft_pkg.sv
package bft_pkg;
  typedef enum logic [3:0] {
    BFT_MODE_CUR,
    BFT_MODE_DO,
    BFT_MODE_SIG,
    BFT_MODE_CUR_AND_DO,
    BFT_MODE_CUR_OR_DO,
    BFT_MODE_CUR_AND_SIG,
    BFT_MODE_CUR_OR_SIG,
    BFT_MODE_SIG_AND_DO,
    BFT_MODE_SIG_OR_DO
  } bft_mode_t;
  typedef enum logic [1:0] {
    BFT_ST_IDLE,
    BFT_ST_RUN,
    BFT_ST_BLOCKED
  } bft_state_t;
endpackage : bft_pkg

// file: hw/bft_delay_timer.sv
`include "bft_regs.svh"
module bft_delay_timer
  import bft_pkg::*;
#(
  parameter int CW = 16
)
(
  input  wire logic          mclk_i,
  input  wire logic          srst_i,
  input  wire logic          tick_i,
  input  wire logic          run_i,
  input  wire logic          en_i,
  input  wire logic [CW-1:0] delay_i,
  output logic               expired_o
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          exp_reg;
  logic          exp_next;

  // Counting only while the pick-up holds; a drop resets the count and the output.
  always_comb
  begin
    cnt_next = cnt_reg;
    exp_next = exp_reg;
    if (!run_i || !en_i)
    begin
      cnt_next = '0;
      exp_next = 1'b0;
    end
    else if (cnt_reg >= delay_i)
    begin
      exp_next = 1'b1; // RULE16
    end
    else if (tick_i)
    begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      cnt_reg <= '0;
      exp_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign expired_o = exp_reg;
endmodule : bft_delay_timer

// file: hw/bft_core.sv
// The implementer's own choices: the address map and the address-and-strobe port.
`include "bft_regs.svh"
// Summary of operation
// RULE1 - One common pick-up starts both timers.
// RULE2 - Retrip enable, default on; off suppresses retrip.
// RULE3 - Retrip after pick-up lasts retrip delay.
// RULE4 - Breaker failure after pick-up lasts its delay.
// RULE5 - User grades retrip delay below failure delay.
// RULE6 - Current mode: pick-up on overcurrent alone.
// RULE7 - Current mode: reset when current drops.
// RULE8 - Current and contact: halt until contact active.
// RULE9 - Current and contact: reset when either drops.
// RULE10 - Current or contact: start on either.
// RULE11 - Current or contact: reset when both drop.
// RULE12 - Retrip disabled: only failure timer runs.
// RULE13 - Release at 97 percent, common phase threshold.
// RULE14 - Block at pick-up shows blocked, resets start.
// RULE15 - Criterion selects current, signals, contact, combinations.
// RULE16 - Expired output holds while pick-up persists.
module bft_core
  import bft_pkg::*;
#(
  parameter int AW = 4,
  parameter int DW = 32,
  parameter int IW = 16,
  parameter int TW = 16,
  parameter int STEP_CYC = (`BFT_STEP_NS + `BFT_CLK_NS - 1) / `BFT_CLK_NS
)
(
  input  wire logic          mclk_i,
  input  wire logic          srst_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic [DW-1:0]      rdata_o,
  input  wire logic [IW-1:0] phase_a_mag_i,
  input  wire logic [IW-1:0] phase_b_mag_i,
  input  wire logic [IW-1:0] phase_c_mag_i,
  input  wire logic [IW-1:0] residual_mag_i,
  input  wire logic          trip_contact_i,
  input  wire logic          trip_signal_i,
  input  wire logic          block_i,
  output logic               start_o,
  output logic               blocked_o,
  output logic               redundant_trip_o,
  output logic               breaker_failure_output,
  output logic               irq_o
);
  localparam int SW = $clog2(STEP_CYC + 1);

  logic [DW-1:0]  ctrl_reg;
  logic [DW-1:0]  ctrl_next;
  logic [TW-1:0]  redundant_trip_delay_setting_reg;
  logic [TW-1:0]  redundant_trip_delay_setting_next;
  logic [TW-1:0]  bf_delay_reg;
  logic [TW-1:0]  bf_delay_next;
  logic [IW-1:0]  phase_thr_reg;
  logic [IW-1:0]  phase_thr_next;
  logic [IW-1:0]  residual_pickup_threshold_reg;
  logic [IW-1:0]  residual_pickup_threshold_next;
  logic [DW-1:0]  rdata_reg;
  logic [DW-1:0]  rdata_next;
  logic [`BFT_NUM_EVT-1:0] irq_stat_reg;
  logic [`BFT_NUM_EVT-1:0] irq_stat_next;
  logic [`BFT_NUM_EVT-1:0] irq_en_reg;
  logic [`BFT_NUM_EVT-1:0] irq_en_next;
  logic [SW-1:0]  step_reg;
  logic [SW-1:0]  step_next;
  logic           tick;
  logic [2:0]     pin_s1_reg;
  logic [2:0]     pin_s2_reg;
  logic           contact_s;
  logic           signal_s;
  logic           block_s;
  logic           ph_oc_reg;
  logic           ph_oc_next;
  logic           res_oc_reg;
  logic           res_oc_next;
  logic           cur_oc;
  logic           pickup;
  bft_state_t     state_reg;
  bft_state_t     state_next;
  bft_mode_t      mode;
  logic           retr_en;
  logic           run;
  logic           retr_exp;
  logic           bf_exp;
  logic [`BFT_NUM_EVT-1:0] evt;
  logic [`BFT_NUM_EVT-1:0] prev_reg;
  logic [`BFT_NUM_EVT-1:0] cur_lvl;

  assign mode    = bft_mode_t'(ctrl_reg[`BFT_CTRL_MODE_MSB:`BFT_CTRL_MODE_LSB]);
  assign retr_en = ctrl_reg[`BFT_CTRL_RETR_EN];

  // Register writes and read mux; unmapped addresses read as zero.
  always_comb
  begin
    ctrl_next = ctrl_reg;
    redundant_trip_delay_setting_next = redundant_trip_delay_setting_reg;
    bf_delay_next = bf_delay_reg;
    phase_thr_next = phase_thr_reg;
    residual_pickup_threshold_next = residual_pickup_threshold_reg;
    irq_en_next = irq_en_reg;
    rdata_next = '0;
    if (wr_i)
    begin
      case (addr_i)
        `BFT_ADDR_CTRL:     ctrl_next = {27'h000_0000, wdata_i[4:0]}; // RULE15
        `BFT_ADDR_RETR_DLY: redundant_trip_delay_setting_next = wdata_i[TW-1:0];
        `BFT_ADDR_BF_DLY:   bf_delay_next = wdata_i[TW-1:0];
        `BFT_ADDR_PH_THR:   phase_thr_next = wdata_i[IW-1:0]; // RULE13
        `BFT_ADDR_RES_THR:  residual_pickup_threshold_next = wdata_i[IW-1:0];
        `BFT_ADDR_IRQ_EN:   irq_en_next = wdata_i[`BFT_NUM_EVT-1:0];
        default:            ctrl_next = ctrl_reg;
      endcase
    end
    if (rd_i)
    begin
      case (addr_i)
        `BFT_ADDR_CTRL:     rdata_next = ctrl_reg;
        // The retrip delay reads zero while retrip is off, as the setting is unavailable.
        `BFT_ADDR_RETR_DLY: rdata_next = retr_en ?
                                         DW'(redundant_trip_delay_setting_reg) : '0; // RULE2
        `BFT_ADDR_BF_DLY:   rdata_next = DW'(bf_delay_reg);
        `BFT_ADDR_PH_THR:   rdata_next = DW'(phase_thr_reg);
        `BFT_ADDR_RES_THR:  rdata_next = DW'(residual_pickup_threshold_reg);
        `BFT_ADDR_STATUS:   rdata_next = DW'(cur_lvl);
        `BFT_ADDR_IRQ_STAT: rdata_next = DW'(irq_stat_reg);
        `BFT_ADDR_IRQ_EN:   rdata_next = DW'(irq_en_reg);
        default:            rdata_next = '0;
      endcase
    end
  end

  // Sticky events; a new event in the clearing cycle survives the clear.
  always_comb
  begin
    irq_stat_next = irq_stat_reg;
    if (wr_i && addr_i == `BFT_ADDR_IRQ_CLR)
    begin
      irq_stat_next = irq_stat_reg & ~wdata_i[`BFT_NUM_EVT-1:0];
    end
    irq_stat_next = irq_stat_next | evt;
  end

  // Program-cycle step divider; one pulse per delay step.
  always_comb
  begin
    step_next = step_reg + 1'b1;
    if (tick)
    begin
      step_next = '0;
    end
  end
  assign tick = (step_reg == SW'(STEP_CYC - 1));

  // Overcurrent with hysteresis: pick-up above threshold, release below 97 percent.
  function automatic logic oc_eval(input logic [IW-1:0] mag, input logic [IW-1:0] thr,
                                   input logic held);
    logic [IW+7:0] lhs;
    logic [IW+7:0] rhs;
    lhs = (IW+8)'(mag) * (IW+8)'(`BFT_RATIO_DEN);
    rhs = (IW+8)'(thr) * (IW+8)'(`BFT_RATIO_NUM);
    if (held)
    begin
      oc_eval = (lhs >= rhs); // RULE13
    end
    else
    begin
      oc_eval = (mag > thr);
    end
  endfunction : oc_eval

  always_comb
  begin
    ph_oc_next = oc_eval(phase_a_mag_i, phase_thr_reg, ph_oc_reg) |
                 oc_eval(phase_b_mag_i, phase_thr_reg, ph_oc_reg) |
                 oc_eval(phase_c_mag_i, phase_thr_reg, ph_oc_reg);
    res_oc_next = oc_eval(residual_mag_i, residual_pickup_threshold_reg, res_oc_reg);
  end
  assign cur_oc = ph_oc_reg | res_oc_reg;

  // Criterion selection of the common pick-up.
  always_comb
  begin
    case (mode)
      BFT_MODE_CUR:         pickup = cur_oc; // RULE6 RULE7
      BFT_MODE_DO:          pickup = contact_s;
      BFT_MODE_SIG:         pickup = signal_s;
      BFT_MODE_CUR_AND_DO:  pickup = cur_oc & contact_s; // RULE8 RULE9
      BFT_MODE_CUR_OR_DO:   pickup = cur_oc | contact_s; // RULE10 RULE11
      BFT_MODE_CUR_AND_SIG: pickup = cur_oc & signal_s;
      BFT_MODE_CUR_OR_SIG:  pickup = cur_oc | signal_s;
      BFT_MODE_SIG_AND_DO:  pickup = signal_s & contact_s;
      BFT_MODE_SIG_OR_DO:   pickup = signal_s | contact_s;
      default:              pickup = cur_oc;
    endcase
  end

  // Blocking at pick-up latches blocked until pick-up drops; a running start resets.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      BFT_ST_IDLE:
      begin
        if (pickup && block_s)
        begin
          state_next = BFT_ST_BLOCKED; // RULE14
        end
        else if (pickup)
        begin
          state_next = BFT_ST_RUN;
        end
      end
      BFT_ST_RUN:
      begin
        if (!pickup)
        begin
          state_next = BFT_ST_IDLE;
        end
        else if (block_s)
        begin
          state_next = BFT_ST_BLOCKED; // RULE14
        end
      end
      BFT_ST_BLOCKED:
      begin
        if (!pickup)
        begin
          state_next = BFT_ST_IDLE;
        end
      end
      default: state_next = BFT_ST_IDLE;
    endcase
  end
  assign run = (state_reg == BFT_ST_RUN) && pickup;

  bft_delay_timer #(.CW(TW)) u_retr_timer (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .tick_i    (tick),
    .run_i     (run), // RULE1
    .en_i      (retr_en), // RULE2 RULE12
    .delay_i   (redundant_trip_delay_setting_reg), // RULE3
    .expired_o (retr_exp)
  );

  bft_delay_timer #(.CW(TW)) u_bf_timer (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .tick_i    (tick),
    .run_i     (run), // RULE1
    .en_i      (1'b1),
    .delay_i   (bf_delay_reg), // RULE4
    .expired_o (bf_exp)
  );

  assign cur_lvl = {state_reg == BFT_ST_BLOCKED, bf_exp, retr_exp, state_reg == BFT_ST_RUN};
  assign evt     = cur_lvl & ~prev_reg;

  // The pins are asynchronous to the relay clock, hence two flops each.
  always_ff @(posedge mclk_i)
  begin
    pin_s1_reg <= {block_i, trip_signal_i, trip_contact_i};
    pin_s2_reg <= pin_s1_reg;
  end
  assign contact_s = pin_s2_reg[0];
  assign signal_s  = pin_s2_reg[1];
  assign block_s   = pin_s2_reg[2];

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      ctrl_reg                         <= `BFT_CTRL_RESET;
      redundant_trip_delay_setting_reg <= `BFT_RETR_DLY_RESET;
      bf_delay_reg                     <= `BFT_BF_DLY_RESET;
      phase_thr_reg                    <= `BFT_PH_THR_RESET;
      residual_pickup_threshold_reg    <= `BFT_RES_THR_RESET;
      rdata_reg                        <= '0;
      irq_stat_reg                     <= '0;
      irq_en_reg                       <= '0;
      step_reg                         <= '0;
      ph_oc_reg                        <= 1'b0;
      res_oc_reg                       <= 1'b0;
      state_reg                        <= BFT_ST_IDLE;
      prev_reg                         <= '0;
    end
    else
    begin
      ctrl_reg                         <= ctrl_next;
      redundant_trip_delay_setting_reg <= redundant_trip_delay_setting_next;
      bf_delay_reg                     <= bf_delay_next;
      phase_thr_reg                    <= phase_thr_next;
      residual_pickup_threshold_reg    <= residual_pickup_threshold_next;
      rdata_reg                        <= rdata_next;
      irq_stat_reg                     <= irq_stat_next;
      irq_en_reg                       <= irq_en_next;
      step_reg                         <= step_next;
      ph_oc_reg                        <= ph_oc_next;
      res_oc_reg                       <= res_oc_next;
      state_reg                        <= state_next;
      prev_reg                         <= cur_lvl;
    end
  end

  assign rdata_o                = rdata_reg;
  assign start_o                = (state_reg == BFT_ST_RUN);
  assign blocked_o              = (state_reg == BFT_ST_BLOCKED);
  assign redundant_trip_o       = retr_exp & retr_en; // RULE2
  assign breaker_failure_output = bf_exp; // RULE12
  assign irq_o                  = |(irq_stat_reg & irq_en_reg);
endmodule : bft_core

// file: test/bft_props.sv
module bft_props
  import bft_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        start_o,
  input wire logic        blocked_o,
  input wire logic        redundant_trip_o,
  input wire logic        breaker_failure_output,
  input wire logic        irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  a_retrip_needs_start: assert property ($rose(redundant_trip_o) |-> start_o)
    else $error("retrip rose without start");
  a_bf_needs_start: assert property ($rose(breaker_failure_output) |-> start_o)
    else $error("failure output rose without start");
  a_start_not_blocked: assert property (!(start_o && blocked_o))
    else $error("start and blocked together");
  a_block_clears_bf: assert property ($rose(blocked_o) |-> ##3 (!blocked_o || !breaker_failure_output))
    else $error("failure output kept while blocked");
  a_bf_holds_run: assert property (breaker_failure_output && start_o |=> breaker_failure_output || !start_o)
    else $error("failure output dropped during pick-up");
  a_rt_holds_run: assert property (redundant_trip_o && start_o |=> redundant_trip_o || !start_o)
    else $error("retrip dropped during pick-up");
  a_reset_quiet: assert property ($past(srst_i) |->
    !(start_o || blocked_o || redundant_trip_o || breaker_failure_output || irq_o))
    else $error("output high after reset");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside read cycle");
  c_bf: cover property ($rose(breaker_failure_output));
  c_blocked: cover property ($rose(blocked_o));
  c_irq: cover property ($rose(irq_o));
endmodule : bft_props

bind bft_core bft_props u_props (.*);

// file: test/bft_trip_model.sv
module bft_trip_model
#(
  parameter int LAT = 3
)
(
  input  wire logic mclk_i,
  input  wire logic trip_cmd_i,
  output logic      contact_o,
  output logic      signal_o
);
  logic [7:0] cnt_reg;
  // The contact closes some cycles after the trip command, like a real relay.
  always_ff @(posedge mclk_i)
  begin
    cnt_reg <= trip_cmd_i ? ((cnt_reg < 8'(LAT)) ? cnt_reg + 8'h01 : cnt_reg) : 8'h00;
    contact_o <= trip_cmd_i && (cnt_reg >= 8'(LAT));
  end
  assign signal_o = trip_cmd_i;
endmodule : bft_trip_model

// file: test/breaker_failure_timer_tb_top.sv
`include "bft_regs.svh"
module breaker_failure_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int S = 4;
  logic             mclk_i;
  logic             srst_i = 1'h1;
  logic [3:0]       addr = 4'h0;
  logic [31:0]      wdata = 32'h0000_0000;
  logic             wr = 1'h0;
  logic             rd = 1'h0;
  logic [15:0]      pa = 16'h0000;
  logic [15:0]      pb = 16'h0000;
  logic [15:0]      pc = 16'h0000;
  logic [15:0]      res = 16'h0000;
  logic             cmd = 1'h0;
  logic             blk = 1'h0;
  wire logic [31:0] rdata;
  wire logic        tc, ts, st, bl, rt, bf, irq;
  wire logic [4:0]  o = {irq, bf, rt, bl, st};
  int               miscompares = 0;
  int               checks = 0;
  int               cyc = 0;

  bft_core #(.STEP_CYC(S)) uut (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .phase_a_mag_i(pa),
    .phase_b_mag_i(pb), .phase_c_mag_i(pc), .residual_mag_i(res),
    .trip_contact_i(tc), .trip_signal_i(ts), .block_i(blk), .start_o(st),
    .blocked_o(bl), .redundant_trip_o(rt), .breaker_failure_output(bf), .irq_o(irq));
  bft_trip_model u_trip (.mclk_i(mclk_i), .trip_cmd_i(cmd), .contact_o(tc), .signal_o(ts));

  initial
  begin
    mclk_i = 1'h0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wreg(logic [3:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge mclk_i);
    wr <= 1'h0;
    @(posedge mclk_i);
  endtask : wreg

  task automatic rreg(logic [3:0] a, logic [31:0] e, string n);
    addr <= a;
    rd <= 1'h1;
    @(posedge mclk_i);
    rd <= 1'h0;
    #1;
    chk(n, rdata, e);
    @(posedge mclk_i);
  endtask : rreg

  task automatic drive(logic [15:0] a, logic c);
    pa <= a;
    cmd <= c;
    cyc = 0;
  endtask : drive

  // Waits on output k for value v; a late phase of the step tick is covered by the bounds.
  task automatic watch(int k, logic v, int lo, int hi, logic w, string n);
    do
    begin
      @(negedge mclk_i);
      cyc++;
    end while (o[k] !== v && cyc < hi);
    chk(n, {cyc >= lo, o[k] === v}, {1'h1, w});
    @(posedge mclk_i);
  endtask : watch

  task automatic t_regs;
    logic [3:0] a[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'hF};
    logic [31:0] e[7] = '{`BFT_CTRL_RESET, `BFT_RETR_DLY_RESET, `BFT_BF_DLY_RESET,
      `BFT_PH_THR_RESET, `BFT_RES_THR_RESET, 32'h0000_0000, 32'h0000_0000};
    for (int i = 0; i < 7; i++)
      rreg(a[i], e[i], "reset_value");
  endtask : t_regs

  task automatic t_cur;
    wreg(4'h1, 32'h0000_0002);
    wreg(4'h2, 32'h0000_0004);
    wreg(4'h8, 32'h0000_000F);
    drive(16'h0020, 1'h0);
    watch(2, 1'h1, S + 2, 2 * S + 6, 1'h1, "retrip_rise");
    chk("bf_early", bf, 1'h0);
    watch(3, 1'h1, 3 * S + 2, 4 * S + 6, 1'h1, "bf_rise");
    chk("irq_on", irq, 1'h1);
    drive(16'h0014, 1'h0);
    watch(3, 1'h0, 10, 10, 1'h0, "bf_hold");
    drive(16'h0013, 1'h0);
    watch(0, 1'h0, 0, 4, 1'h1, "release");
    chk("rt_release", rt, 1'h0);
    rreg(4'h6, 32'h0000_0007, "irq_stat");
    wreg(4'h7, 32'h0000_000F);
    wreg(4'h8, 32'h0000_0000);
    chk("irq_clear", irq, 1'h0);
  endtask : t_cur

  task automatic t_and;
    wreg(4'h0, 32'h0000_0007);
    drive(16'h0020, 1'h0);
    watch(0, 1'h1, 20, 20, 1'h0, "and_halt");
    drive(16'h0020, 1'h1);
    watch(2, 1'h1, S + 2, 2 * S + 12, 1'h1, "and_retrip");
    drive(16'h0020, 1'h0);
    watch(0, 1'h0, 0, 6, 1'h1, "and_release");
    chk("irq_masked", irq, 1'h0);
    drive(16'h0000, 1'h0);
  endtask : t_and

  task automatic t_or;
    wreg(4'h0, 32'h0000_0009);
    drive(16'h0000, 1'h1);
    watch(0, 1'h1, 0, 10, 1'h1, "or_start");
    drive(16'h0020, 1'h0);
    watch(0, 1'h0, 10, 10, 1'h0, "or_hold");
    drive(16'h0000, 1'h0);
    watch(0, 1'h0, 0, 4, 1'h1, "or_release");
  endtask : t_or

  task automatic t_noretrip;
    wreg(4'h0, 32'h0000_0000);
    rreg(4'h1, 32'h0000_0000, "retrip_dly_off");
    // Phase C alone carries the fault here, so the third phase comparator is exercised.
    pc <= 16'h0020;
    drive(16'h0000, 1'h0);
    watch(3, 1'h1, 3 * S + 2, 4 * S + 6, 1'h1, "bf_only");
    chk("rt_off", rt, 1'h0);
    pc <= 16'h0000;
    drive(16'h0000, 1'h0);
    repeat (4) @(posedge mclk_i);
  endtask : t_noretrip

  task automatic t_block;
    wreg(4'h0, 32'h0000_0001);
    blk <= 1'h1;
    repeat (4) @(posedge mclk_i);
    drive(16'h0020, 1'h0);
    watch(1, 1'h1, 0, 6, 1'h1, "blocked");
    watch(3, 1'h1, 30, 30, 1'h0, "blk_no_bf");
    blk <= 1'h0;
    drive(16'h0000, 1'h0);
    repeat (6) @(posedge mclk_i);
    drive(16'h0020, 1'h0);
    watch(0, 1'h1, 0, 4, 1'h1, "blk_run");
    blk <= 1'h1;
    watch(1, 1'h1, 0, 12, 1'h1, "blk_late");
    chk("blk_start", st, 1'h0);
    rreg(4'h5, 32'h0000_0008, "status_blocked");
    blk <= 1'h0;
    drive(16'h0000, 1'h0);
    repeat (6) @(posedge mclk_i);
  endtask : t_block

  task automatic t_modes;
    for (int m = 0; m < 9; m++)
    begin
      wreg(4'h0, {27'h0, 4'(m), 1'h1});
      pb <= 16'h0020;
      res <= 16'h04B1;
      drive(16'h0000, 1'h1);
      watch(0, 1'h1, 0, 12, 1'h1, "mode_start");
      pb <= 16'h0000;
      res <= 16'h0000;
      drive(16'h0000, 1'h0);
      watch(0, 1'h0, 0, 12, 1'h1, "mode_release");
    end
  endtask : t_modes

  initial
  begin
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'h0;
    @(posedge mclk_i);
    t_regs;
    t_cur;
    t_and;
    t_or;
    t_noretrip;
    t_block;
    t_modes;
    report_and_stop;
  end

  initial
  begin
    #1000000;
    miscompares++;
    report_and_stop;
  end
endmodule : breaker_failure_timer_tb_top
